/* wdog_core.sv */
// Purpose: Prescaled 8-bit watchdog / interval timer with feed keys
// Assumes: clk_i is the oscillator; bus signals synchronous
// Notes: Reset and power-down outputs go to the system controller
//
// Contract
// - Divide by 12, 13 stages, tap 6-13
// - Main counter decrements on each tap tick
// - At zero a tick underflows and reloads
// - Counter and reload eight bits, any value
// - Every reload clears the prescaler
// - Minimum timeout is 12 times 64 clocks
// - Maximum timeout is minimum times 128 times 256
// - Underflow raises wdog_irq_o only outside watchdog mode
// - Power-down ignored while the watchdog runs
// - Three-bit tap field sets the divisor
// - Feed reloads counter and clears prescaler
// - Watchdog-mode underflow resets system, sets flag
// - Bad feed key sequence resets immediately
`default_nettype none
module wdog_core
   import wdog_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire wdog_pkg::bus_req_t bus_i,
   input wire logic irq_ack_i,
   output logic [wdog_pkg::DATA_W-1:0] rdata_o,
   output logic irq_o,
   output logic wdog_irq_o,
   output logic wdog_irq_prio_o,
   output logic sys_reset_o,
   output logic power_down_o,
   output logic idle_o
);
   import wdog_pkg::*;

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] reload_value;
      logic [2:0] tap_select;
      logic run_control;
      logic mode_select;
      logic mode_clr_pend;
      logic timeout_flag;
      logic armed;
      logic global_irq_enable;
      logic wdog_irq_enable;
      logic wdog_irq_priority;
      logic [EV_W-1:0] ev_stat;
      logic [EV_W-1:0] ev_mask;
      logic [DATA_W-1:0] rdata;
      logic irq;
      logic wirq;
      logic rst_out;
      logic down_pulse;
      logic idle_pulse;
   } core_state_t;

   core_state_t st_reg;
   core_state_t st_next;
   logic tick;
   logic active;
   logic underflow;
   logic feed_ok;
   logic feed_bad;
   logic wr_f1;
   logic wr_f2;
   logic pre_clr;
   logic down_req;
   logic down_block;
   logic [EV_W-1:0] ev;

   // Register hit, used for the feed and power-down decodes
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ==========================================================
   // Prescaler
   wdog_prescaler u_pre (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .en_i(active),
      .clr_i(pre_clr),
      .tap_i(st_reg.tap_select),
      .tick_o(tick)
   );

   // ==========================================================
   // Feed sequence and counter events
   // Watchdog mode runs regardless of the run bit
   assign active = st_reg.mode_select | st_reg.run_control;
   assign wr_f1 = bus_i.wr && hit(bus_i.addr, OFS_FEED1);
   assign wr_f2 = bus_i.wr && hit(bus_i.addr, OFS_FEED2);
   assign feed_ok = st_reg.armed && wr_f2 && bus_i.wdata == FEED_KEY2;
   // Armed cycle must hold the second key, nothing else
   assign feed_bad = (st_reg.armed && !feed_ok) || (!st_reg.armed && wr_f2)
      || (!st_reg.armed && wr_f1 && bus_i.wdata != FEED_KEY1);
   assign underflow = tick && st_reg.count == 8'h00_00;
   assign pre_clr = feed_ok || underflow;
   assign down_req = bus_i.wr && hit(bus_i.addr, OFS_POWER) && bus_i.wdata[PWR_DOWN];
   assign down_block = down_req && active;
   assign ev = {down_block, feed_bad, underflow};

   // ==========================================================
   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.armed = 1'b0;
      st_next.rst_out = 1'b0;
      st_next.down_pulse = 1'b0;
      st_next.idle_pulse = 1'b0;
      st_next.rdata = '0;

      // Software writes
      if (bus_i.wr)
      begin
         case (bus_i.addr)
            OFS_CTRL:
            begin
               st_next.tap_select = bus_i.wdata[CTRL_TAP_LSB +: 3];
               st_next.run_control = bus_i.wdata[CTRL_RUN];
               st_next.timeout_flag = bus_i.wdata[CTRL_TOF];
               // Clearing watchdog mode needs a following feed
               if (bus_i.wdata[CTRL_MODE])
               begin
                  st_next.mode_select = 1'b1;
                  st_next.mode_clr_pend = 1'b0;
               end
               else if (st_reg.mode_select)
               begin
                  st_next.mode_clr_pend = 1'b1;
               end
            end
            OFS_RELOAD: st_next.reload_value = bus_i.wdata;
            OFS_IRQCFG:
            begin
               st_next.global_irq_enable = bus_i.wdata[CFG_GIE];
               st_next.wdog_irq_enable = bus_i.wdata[CFG_WIE];
               st_next.wdog_irq_priority = bus_i.wdata[CFG_PRIO];
            end
            OFS_POWER:
            begin
               // Power-down takes precedence over idle
               if (bus_i.wdata[PWR_DOWN])
                  st_next.down_pulse = !active;
               else
                  st_next.idle_pulse = bus_i.wdata[PWR_IDLE];
            end
            OFS_STAT: st_next.ev_stat = st_reg.ev_stat & ~bus_i.wdata[EV_W-1:0];
            OFS_MASK: st_next.ev_mask = bus_i.wdata[EV_W-1:0];
            default: ;
         endcase
      end

      // Timer-mode interrupt taken clears the flag
      if (irq_ack_i && !st_reg.mode_select)
         st_next.timeout_flag = 1'b0;

      // First key arms for exactly the next cycle
      if (!st_reg.armed && wr_f1 && bus_i.wdata == FEED_KEY1)
         st_next.armed = 1'b1;

      if (feed_ok)
      begin
         st_next.count = st_reg.reload_value;
         if (st_reg.mode_clr_pend)
         begin
            st_next.mode_select = 1'b0;
            st_next.mode_clr_pend = 1'b0;
         end
      end
      else if (underflow)
      begin
         st_next.count = st_reg.reload_value;
      end
      else if (tick)
      begin
         st_next.count = st_reg.count - 8'h00_01;
      end

      // flag set wins over software clear
      if (underflow)
         st_next.timeout_flag = 1'b1;

      st_next.rst_out = (underflow && st_reg.mode_select) || feed_bad;

      // Sticky events, set wins over write-one clear
      st_next.ev_stat = st_next.ev_stat | ev;

      // Read data one cycle after the strobe
      if (bus_i.rd)
      begin
         case (bus_i.addr)
            OFS_CTRL:
            begin
               st_next.rdata[CTRL_TAP_LSB +: 3] = st_reg.tap_select;
               st_next.rdata[CTRL_RUN] = st_reg.run_control;
               st_next.rdata[CTRL_TOF] = st_reg.timeout_flag;
               st_next.rdata[CTRL_MODE] = st_reg.mode_select;
            end
            OFS_RELOAD: st_next.rdata = st_reg.reload_value;
            OFS_IRQCFG:
            begin
               st_next.rdata[CFG_GIE] = st_reg.global_irq_enable;
               st_next.rdata[CFG_WIE] = st_reg.wdog_irq_enable;
               st_next.rdata[CFG_PRIO] = st_reg.wdog_irq_priority;
            end
            OFS_COUNT: st_next.rdata = st_reg.count;
            OFS_STAT: st_next.rdata[EV_W-1:0] = st_reg.ev_stat;
            OFS_MASK: st_next.rdata[EV_W-1:0] = st_reg.ev_mask;
            default: st_next.rdata = '0;
         endcase
      end

      // Interrupt outputs from next-state so they are flops
      st_next.irq = |(st_next.ev_stat & st_next.ev_mask);
      // timer-mode request, gated by both enables
      st_next.wirq = st_next.timeout_flag && !st_next.mode_select
         && st_next.wdog_irq_enable && st_next.global_irq_enable;
   end

   // ==========================================================
   // State register; reset performs the autoload
   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         st_reg <= '0;
         st_reg.reload_value <= RELOAD_RST;
         st_reg.count <= RELOAD_RST;
         st_reg.tap_select <= TAP_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flops
   assign rdata_o = st_reg.rdata;
   assign irq_o = st_reg.irq;
   assign wdog_irq_o = st_reg.wirq;
   assign wdog_irq_prio_o = st_reg.wdog_irq_priority;
   assign sys_reset_o = st_reg.rst_out;
   assign power_down_o = st_reg.down_pulse;
   assign idle_o = st_reg.idle_pulse;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   reload_uflow_a: assert property (
      underflow && !feed_ok |=> st_reg.count == $past(st_reg.reload_value))
      else $error("no reload on underflow");
   count_dec_a: assert property (
      tick && st_reg.count != 8'h00_00 && !feed_ok
      |=> st_reg.count == $past(st_reg.count) - 8'h00_01)
      else $error("counter did not step down");
   count_hold_a: assert property (
      !tick && !feed_ok |=> st_reg.count == $past(st_reg.count))
      else $error("counter moved without tick");
   feed_reload_a: assert property (
      feed_ok |=> st_reg.count == $past(st_reg.reload_value) && !tick)
      else $error("feed did not reload");
   flag_set_a: assert property (
      underflow |=> st_reg.timeout_flag)
      else $error("timeout flag not set");
   mode_reset_a: assert property (
      underflow && st_reg.mode_select |=> sys_reset_o ##1 (!sys_reset_o || $past(feed_bad)))
      else $error("no reset on watchdog underflow");
   timer_noreset_a: assert property (
      underflow && !st_reg.mode_select && !feed_bad |=> !sys_reset_o)
      else $error("timer mode caused reset");
   bad_key_a: assert property (
      st_reg.armed && !(wr_f2 && bus_i.wdata == FEED_KEY2) |=> sys_reset_o)
      else $error("broken feed not reset");
   down_block_a: assert property (
      down_req && active |=> !power_down_o && st_reg.ev_stat[EV_PDBLK])
      else $error("power-down entered while running");
   irq_gate_a: assert property (
      wdog_irq_o |-> st_reg.wdog_irq_enable && st_reg.global_irq_enable
      && !st_reg.mode_select)
      else $error("interrupt passed a closed gate");
   min_tick_a: assert property (
      pre_clr && st_reg.tap_select == 3'h0 && active ##1 active [*8]
      |-> !tick)
      else $error("tick too soon after clear");

   feed_c: cover property (feed_ok);
   wd_reset_c: cover property (underflow && st_reg.mode_select);
   timer_irq_c: cover property (wdog_irq_o);
   down_block_c: cover property (down_block);
endmodule
`default_nettype wire

/* wdog_pkg.sv */
// Purpose: Shared constants and types for the watchdog block
// Assumes: clk_i is the oscillator clock, 8-bit register port
// Notes: Offsets are register indices on the plain port
`default_nettype none
package wdog_pkg;
   // ==========================================================
   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // ==========================================================
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_RELOAD = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_FEED1 = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_FEED2 = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQCFG = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_POWER = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_STAT = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;

   // ==========================================================
   // Field positions
   localparam int CTRL_TAP_LSB = 5;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_TOF = 1;
   localparam int CTRL_MODE = 0;
   localparam int CFG_GIE = 7;
   localparam int CFG_WIE = 6;
   localparam int CFG_PRIO = 0;
   localparam int PWR_DOWN = 1;
   localparam int PWR_IDLE = 0;
   localparam int EV_W = 3;
   localparam int EV_UFLOW = 0;
   localparam int EV_FEEDERR = 1;
   localparam int EV_PDBLK = 2;

   // ==========================================================
   // Reset values, keys, prescaler shape
   localparam logic [7:0] RELOAD_RST = 8'h00_FF;
   localparam logic [2:0] TAP_RST = 3'h7;
   localparam logic [7:0] FEED_KEY1 = 8'h00_A5;
   localparam logic [7:0] FEED_KEY2 = 8'h00_5A;
   localparam int PRE_DIV = 12;
   localparam int PRE_STAGES = 13;
   localparam int PRE_TAP_MIN = 6;
endpackage
`default_nettype wire

/* wdog_prescaler.sv */
// Purpose: Divide-by-12 followed by a 13-stage counter with taps
// Assumes: tap_i stable between clears
// Notes: Tick pulses when the selected tap rolls over
`default_nettype none
module wdog_prescaler
   import wdog_pkg::*;
#(
   parameter int DIV = PRE_DIV,
   parameter int STAGES = PRE_STAGES
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic en_i,
   input wire logic clr_i,
   input wire logic [2:0] tap_i,
   output logic tick_o
);
   import wdog_pkg::*;

   typedef struct packed {
      logic [3:0] div;
      logic [STAGES-1:0] stage;
   } pre_state_t;

   pre_state_t st_reg;
   pre_state_t st_next;
   logic div_wrap;
   logic [STAGES-1:0] tap_mask;

   // ==========================================================
   // Tap mask and rollover
   // tap select
   assign tap_mask = STAGES'((1 << (PRE_TAP_MIN + int'(tap_i))) - 1);
   assign div_wrap = (st_reg.div == 4'(DIV - 1));
   // divisor 768 times two power tap
   // Not gated by the clear: the clear is built from this tick
   assign tick_o = en_i && div_wrap && ((st_reg.stage & tap_mask) == tap_mask);

   // Next state; clear wins so a reload restarts a full period
   always_comb
   begin
      st_next = st_reg;
      if (clr_i)
      begin
         st_next = '0;
      end
      else if (en_i)
      begin
         st_next.div = div_wrap ? 4'h0 : st_reg.div + 4'h1;
         if (div_wrap)
         begin
            st_next.stage = st_reg.stage + STAGES'(1);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // ==========================================================
   // Checks
   tick_cause_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      tick_o |-> st_reg.div == 4'(DIV - 1) && &(st_reg.stage[PRE_TAP_MIN-1:0]))
      else $error("prescaler tick without rollover");
   clr_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      clr_i |=> st_reg == '0)
      else $error("prescaler not cleared");
endmodule
`default_nettype wire

/* cpu_model.sv */
// Purpose: Processor-side model driving the watchdog register port
// Assumes: One clock; strobes change right after a rising edge
// Notes: Idle data is inverted so a stale value never looks fresh
`default_nettype none
module cpu_model
(
   input wire logic clk_i,
   input wire logic [wdog_pkg::DATA_W-1:0] rdata_i,
   output var wdog_pkg::bus_req_t bus_o,
   output var logic irq_ack_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import wdog_pkg::*;

   // ==========================================================
   // Bus cycles
   // Quiet bus at time zero
   initial
   begin
      bus_o = '0;
      irq_ack_o = 1'b0;
   end

   // Drop strobes, scramble the released data
   task automatic idle();
      @(posedge clk_i);
      bus_o.wr <= 1'b0;
      bus_o.rd <= 1'b0;
      bus_o.wdata <= ~bus_o.wdata;
   endtask

   // One strobe cycle, write or read
   task automatic put(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      bus_o <= '{addr: a, wdata: d, wr: w, rd: !w};
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      put(1'b1, a, d);
      idle();
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
      put(1'b0, a, '0);
      idle();
      #1;
      q = rdata_i;
   endtask

   // Two accesses on consecutive cycles
   task automatic pair(input logic [ADDR_W-1:0] a1, input logic [DATA_W-1:0] d1,
                       input logic w2, input logic [ADDR_W-1:0] a2,
                       input logic [DATA_W-1:0] d2);
      put(1'b1, a1, d1);
      put(w2, a2, d2);
      idle();
   endtask

   // dedicated feed routine, keys back to back
   task automatic feed();
      pair(OFS_FEED1, FEED_KEY1, 1'b1, OFS_FEED2, FEED_KEY2);
   endtask

   // Interrupt taken by the core
   task automatic ack();
      @(posedge clk_i);
      irq_ack_o <= 1'b1;
      @(posedge clk_i);
      irq_ack_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* watchdog_prescaled_downcounter_tb_top.sv */
// Purpose: Self-checking bench for the prescaled watchdog
// Assumes: 250 MHz clock, full-length prescaler
// Notes: Periods are timed between reset pulses, not from a feed
`default_nettype none
module watchdog_prescaled_downcounter_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wdog_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   bus_req_t bus;
   logic irq_ack, irq, wirq, wprio, rst_o, pwr_dn, idle_out;
   logic [DATA_W-1:0] rdata, q;
   int err_count = 0, checked = 0, cyc = 0, n, m;
   int rst_cnt = 0, rst_last = 0, rst_gap = 0, dn_cnt = 0, idle_cnt = 0;

   wdog_core i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .irq_ack_i(irq_ack),
      .rdata_o(rdata), .irq_o(irq), .wdog_irq_o(wirq), .wdog_irq_prio_o(wprio),
      .sys_reset_o(rst_o), .power_down_o(pwr_dn), .idle_o(idle_out));
   cpu_model i_cpu (.clk_i(clk_i), .rdata_i(rdata), .bus_o(bus), .irq_ack_o(irq_ack));

   // ==========================================================
   // Clock, pulse monitor, hang guard
   always #2 clk_i = ~clk_i;

   // Count one-cycle pulses and the spacing of resets
   always @(posedge clk_i)
   begin
      cyc++;
      if (rst_o === 1'b1)
      begin
         rst_cnt++;
         rst_gap = cyc - rst_last;
         rst_last = cyc;
      end
      if (pwr_dn === 1'b1) dn_cnt++;
      if (idle_out === 1'b1) idle_cnt++;
   end

   // Whole run needs about 16500 cycles
   always @(posedge clk_i)
   if (cyc >= 40000)
   begin
      err_count++;
      close_out();
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      i_cpu.rd(a, q);
      check(q, e);
   endtask

   task automatic close_out();
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog mode period; the third gap avoids the feed edge
   task automatic measure(input logic [2:0] tap, input logic [7:0] w);
      int base;
      int exp;
      exp = PRE_DIV * (1 << PRE_TAP_MIN) * (w + 1) * (1 << tap);
      i_cpu.wr(OFS_RELOAD, w);
      i_cpu.wr(OFS_CTRL, {tap, 5'h01});
      i_cpu.feed();
      base = rst_cnt;
      for (int i = 0; i < 8000 && rst_cnt < base + 3; i++) @(posedge clk_i);
      check(rst_gap, exp);
      rdchk(OFS_CTRL, {tap, 5'h03});
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rdchk(OFS_CTRL, {TAP_RST, 5'h00});
      rdchk(OFS_RELOAD, RELOAD_RST);
      rdchk(OFS_COUNT, 8'h00_FF);
      rdchk(OFS_STAT, 8'h00_00);
      rdchk(4'hF, 8'h00_00);
      $display("test reset done");
      // Timer mode counting
      i_cpu.wr(OFS_RELOAD, 8'h00_05);
      i_cpu.wr(OFS_CTRL, 8'h00_04);
      i_cpu.feed();
      rdchk(OFS_COUNT, 8'h00_05);
      repeat (800) @(posedge clk_i);
      i_cpu.wr(OFS_COUNT, 8'h00_00);
      rdchk(OFS_COUNT, 8'h00_04);
      n = dn_cnt;
      i_cpu.wr(OFS_POWER, 8'h00_02);
      repeat (3) @(posedge clk_i);
      check(dn_cnt, n);
      i_cpu.rd(OFS_STAT, q);
      check(q & 8'h00_04, 8'h00_04);
      $display("test count done");
      // Timer mode interrupt
      i_cpu.wr(OFS_RELOAD, 8'h00_00);
      i_cpu.wr(OFS_IRQCFG, 8'h00_C1);
      i_cpu.wr(OFS_MASK, 8'h00_01);
      i_cpu.wr(OFS_STAT, 8'h00_07);
      i_cpu.feed();
      n = rst_cnt;
      for (int i = 0; i < 1000 && wirq !== 1'b1; i++) @(posedge clk_i);
      repeat (2) @(posedge clk_i);
      check({wirq, irq, wprio}, 3'b111);
      check(rst_cnt, n);
      i_cpu.ack();
      i_cpu.wr(OFS_STAT, 8'h00_01);
      repeat (2) @(posedge clk_i);
      check({wirq, irq}, 2'b00);
      i_cpu.wr(OFS_IRQCFG, 8'h00_40);
      i_cpu.wr(OFS_MASK, 8'h00_00);
      repeat (800) @(posedge clk_i);
      check({wirq, irq, wprio}, 3'b000);
      rdchk(OFS_STAT, 8'h00_01);
      i_cpu.wr(OFS_MASK, 8'h00_01);
      repeat (2) @(posedge clk_i);
      check(irq, 1'b1);
      $display("test interrupt done");
      // Watchdog mode periods
      // Both enables open: watchdog mode must still keep its request down
      i_cpu.wr(OFS_IRQCFG, 8'h00_C0);
      measure(3'h0, 8'h00_00);
      measure(3'h1, 8'h00_00);
      measure(3'h0, 8'h00_02);
      check({wirq, irq}, 2'b01);
      $display("test period done");
      // Good feed, then four broken key sequences
      n = rst_cnt;
      i_cpu.feed();
      i_cpu.wr(OFS_FEED1, FEED_KEY1);
      i_cpu.pair(OFS_FEED1, FEED_KEY1, 1'b0, OFS_COUNT, 8'h00_00);
      i_cpu.wr(OFS_FEED2, FEED_KEY2);
      i_cpu.wr(OFS_FEED1, 8'h00_11);
      repeat (3) @(posedge clk_i);
      check(rst_cnt, n + 4);
      rdchk(OFS_STAT, 8'h00_03);
      $display("test feed done");
      // Leave watchdog mode, power-down granted
      i_cpu.wr(OFS_CTRL, 8'h00_00);
      i_cpu.feed();
      rdchk(OFS_CTRL, 8'h00_00);
      n = dn_cnt;
      m = idle_cnt;
      i_cpu.wr(OFS_POWER, 8'h00_03);
      repeat (3) @(posedge clk_i);
      check(dn_cnt, n + 1);
      check(idle_cnt, m);
      i_cpu.wr(OFS_POWER, 8'h00_01);
      repeat (3) @(posedge clk_i);
      check(idle_cnt, m + 1);
      $display("test power done");
      close_out();
   end
endmodule
`default_nettype wire
